// File: core/mdf_pkg.sv
/*
  Constants and types shared by the multiply-divide unit and its helpers.
  Assumes a single microengine clock; one microcycle is one clock cycle.
*/
package mdf_pkg;

  // ==========================================================
  // Widths
  localparam int unsigned WORD_W = 24;
  localparam int unsigned ACC_W = 48;
  localparam int unsigned STAGE_W = 32;
  localparam int unsigned STAGE_FLAG_LSB = 24;
  localparam int unsigned STAGE_FLAG_W = 8;
  localparam int unsigned FRAC8_SHIFT = 16;
  localparam int unsigned FRAC16_SHIFT = 8;

  // ==========================================================
  // Timing: clock period in ns, operation lengths in microcycles including the start cycle
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam logic [3:0] DIV_CYCLES = 4'hd;
  localparam logic [3:0] MUL8_CYCLES = 4'h2;
  localparam logic [3:0] MUL16_CYCLES = 4'h3;
  localparam logic [3:0] MUL24_CYCLES = 4'h4;
  localparam logic [3:0] CNT_ONE = 4'h1;

  // ==========================================================
  // Result constants
  localparam logic [23:0] DIV_ZERO_QUOT = 24'hffffff;
  localparam logic [23:0] WORD_ZERO = 24'h000000;

  // ==========================================================
  // Operation and operand size encodings
  typedef enum logic [2:0] {
    MDF_OP_MULS = 3'h0,
    MDF_OP_MULU = 3'h1,
    MDF_OP_MACS = 3'h2,
    MDF_OP_MACU = 3'h3,
    MDF_OP_FMULS = 3'h4,
    MDF_OP_FMULU = 3'h5,
    MDF_OP_DIVU = 3'h6
  } mdf_op_e;

  typedef enum logic [1:0] {
    MDF_SZ_8 = 2'h0,
    MDF_SZ_16 = 2'h1,
    MDF_SZ_24 = 2'h2
  } mdf_size_e;

  // Branch flag group selection
  typedef enum logic [2:0] {
    MDF_GRP_ALU = 3'h0,
    MDF_GRP_MDU = 3'h1,
    MDF_GRP_STAGE = 3'h2,
    MDF_GRP_CHAN = 3'h3,
    MDF_GRP_SEM = 3'h4
  } mdf_grp_e;

  typedef enum logic [0:0] {
    MDF_ST_IDLE = 1'h0,
    MDF_ST_RUN = 1'h1
  } mdf_state_e;

endpackage

// File: core/mdf_product.sv
/*
  Combinational product and accumulate arithmetic for the multiply-divide unit.
  Assumes operands stay stable while the caller samples the outputs.
*/
`timescale 1ns/10ps
`default_nettype none

module mdf_product (
  // Operation
  input wire mdf_pkg::mdf_op_e op,
  input wire mdf_pkg::mdf_size_e size,
  // Operands and accumulator
  input wire logic [23:0] first_operand,
  input wire logic [23:0] second_operand,
  input wire logic [47:0] acc,
  // Result
  output logic [47:0] result,
  output logic acc_overflow
);

  logic signed [24:0] a_ext;
  logic signed [24:0] b_ext;
  logic signed [49:0] prod;
  logic signed [49:0] sum;
  logic a_sgn;
  logic b_sgn;

  // ==========================================================
  // Operand extension: fractional ops take the second operand unsigned
  always_comb begin
    a_sgn = (op == mdf_pkg::MDF_OP_MULS) || (op == mdf_pkg::MDF_OP_MACS) ||
            (op == mdf_pkg::MDF_OP_FMULS);
    b_sgn = (op == mdf_pkg::MDF_OP_MULS) || (op == mdf_pkg::MDF_OP_MACS);
    a_ext = {a_sgn & first_operand[23], first_operand};
    b_ext = {b_sgn & second_operand[23], second_operand};
  end

  // ==========================================================
  // Product, fractional alignment and accumulate
  always_comb begin
    prod = a_ext * b_ext;
    if (op == mdf_pkg::MDF_OP_FMULS || op == mdf_pkg::MDF_OP_FMULU) begin
      // Integer part lands in the high word, fraction over 2^24 in the low word
      if (size == mdf_pkg::MDF_SZ_8) begin
        prod = prod <<< mdf_pkg::FRAC8_SHIFT;
      end else if (size == mdf_pkg::MDF_SZ_16) begin
        prod = prod <<< mdf_pkg::FRAC16_SHIFT;
      end
      // Size 24 is the ordinary multiply
    end
    sum = prod;
    acc_overflow = 1'b0;
    if (op == mdf_pkg::MDF_OP_MACS) begin
      sum = prod + {{2{acc[47]}}, acc};
      acc_overflow = (sum[49:47] != {3{sum[47]}});
    end else if (op == mdf_pkg::MDF_OP_MACU) begin
      sum = prod + {2'b00, acc};
      acc_overflow = (sum[49:48] != 2'b00);
    end
    result = sum[47:0];
  end

endmodule
`default_nettype wire

// File: core/mdf_divider.sv
/*
  Restoring unsigned divider, two quotient bits per edge; the start edge
  does the first pair, so 24 bits are done eleven edges after start.
  Assumes the caller pulses start once and then issues step enables.
*/
`timescale 1ns/10ps
`default_nettype none

module mdf_divider (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Control
  input wire logic start,
  input wire logic step,
  // Operands
  input wire logic [23:0] dividend,
  input wire logic [23:0] divisor,
  // Results
  output logic [23:0] quotient,
  output logic [23:0] remainder
);

  logic [23:0] dsr;
  logic [23:0] q_src;
  logic [23:0] r_src;
  logic [23:0] d_src;
  logic [24:0] trial_a;
  logic [24:0] trial_b;
  logic [23:0] q_a;
  logic [23:0] r_a;
  logic [23:0] q_b;
  logic [23:0] r_b;

  // Two restoring steps per edge; one divide fits in thirteen microcycles
  always_comb begin
    q_src = start ? dividend : quotient;
    r_src = start ? 24'h000000 : remainder;
    d_src = start ? divisor : dsr;
    trial_a = {r_src, q_src[23]} - {1'b0, d_src};
    r_a = trial_a[24] ? {r_src[22:0], q_src[23]} : trial_a[23:0];
    q_a = {q_src[22:0], ~trial_a[24]};
    trial_b = {r_a, q_a[23]} - {1'b0, d_src};
    r_b = trial_b[24] ? {r_a[22:0], q_a[23]} : trial_b[23:0];
    q_b = {q_a[22:0], ~trial_b[24]};
  end

  // ==========================================================
  // Shift-subtract state
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      quotient <= 24'h000000;
      remainder <= 24'h000000;
      dsr <= 24'h000000;
    end else if (start) begin
      quotient <= q_b;
      remainder <= r_b;
      dsr <= divisor;
    end else if (step) begin
      quotient <= q_b;
      remainder <= r_b;
    end
  end

endmodule
`default_nettype wire

// File: core/mdf_unit.sv
/*
  Multiply, fractional multiply and divide unit with its five flags and the
  branch condition selector for the microengine.
  Assumes one start per operation from the sequencer, and that the alu,
  channel and staging register flags come from same-clock logic.
*/
`timescale 1ns/10ps
`default_nettype none

module mdf_unit (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Operation start from the sequencer
  input wire logic start,
  input wire mdf_pkg::mdf_op_e op,
  input wire mdf_pkg::mdf_size_e size,
  input wire logic [23:0] first_operand,
  input wire logic [23:0] second_operand,
  // Thread control
  input wire logic thread_start,
  input wire logic thread_end,
  // Semaphore results
  input wire logic sem_lock_try,
  input wire logic sem_lock_won,
  input wire logic sem_free,
  // Branch inputs
  input wire mdf_pkg::mdf_grp_e branch_group,
  input wire logic [2:0] branch_bit,
  input wire logic [3:0] alu_flags,
  input wire logic [7:0] chan_flags,
  input wire logic [31:0] staging_register,
  // Results
  output logic [23:0] result_high_word,
  output logic [23:0] result_low_word,
  // Flags
  output logic muldiv_carry_flag,
  output logic muldiv_zero_flag,
  output logic muldiv_overflow_flag,
  output logic muldiv_negative_flag,
  output logic muldiv_busy_flag,
  output logic semaphore_locked_flag,
  output logic branch_cond
);

  mdf_pkg::mdf_state_e state;
  mdf_pkg::mdf_op_e cur_op;
  mdf_pkg::mdf_size_e cur_size;
  logic [23:0] a_hold;
  logic [23:0] b_hold;
  logic [3:0] remain;
  logic [3:0] next_remain;
  logic [47:0] prod_result;
  logic prod_ovf;
  logic [23:0] div_quot;
  logic [23:0] div_rem;
  logic finish;
  logic is_div;
  logic is_mac;
  logic [47:0] fin_result;

  // ==========================================================
  // Arithmetic helpers
  mdf_product u_product (
    .op(cur_op),
    .size(cur_size),
    .first_operand(a_hold),
    .second_operand(b_hold),
    .acc({result_high_word, result_low_word}),
    .result(prod_result),
    .acc_overflow(prod_ovf)
  );

  mdf_divider u_divider (
    .core_clk(core_clk),
    .rstn(rstn),
    .start(start && !thread_end && op == mdf_pkg::MDF_OP_DIVU),
    .step(state == mdf_pkg::MDF_ST_RUN && cur_op == mdf_pkg::MDF_OP_DIVU),
    .dividend(first_operand),
    .divisor(second_operand),
    .quotient(div_quot),
    .remainder(div_rem)
  );

  // ==========================================================
  // Operation length including the start cycle
  always_comb begin
    if (op == mdf_pkg::MDF_OP_DIVU) begin
      next_remain = mdf_pkg::DIV_CYCLES - mdf_pkg::CNT_ONE;
    end else if (op == mdf_pkg::MDF_OP_MACS || op == mdf_pkg::MDF_OP_MACU) begin
      next_remain = mdf_pkg::MUL24_CYCLES - mdf_pkg::CNT_ONE;
    end else begin
      case (size)
        mdf_pkg::MDF_SZ_8: next_remain = mdf_pkg::MUL8_CYCLES - mdf_pkg::CNT_ONE;
        mdf_pkg::MDF_SZ_16: next_remain = mdf_pkg::MUL16_CYCLES - mdf_pkg::CNT_ONE;
        default: next_remain = mdf_pkg::MUL24_CYCLES - mdf_pkg::CNT_ONE;
      endcase
    end
  end

  assign finish = (state == mdf_pkg::MDF_ST_RUN) && (remain == mdf_pkg::CNT_ONE) && !thread_end;
  assign is_div = (cur_op == mdf_pkg::MDF_OP_DIVU);
  assign is_mac = (cur_op == mdf_pkg::MDF_OP_MACS) || (cur_op == mdf_pkg::MDF_OP_MACU);

  // ==========================================================
  // Sequencer of the unit
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= mdf_pkg::MDF_ST_IDLE;
      remain <= 4'h0;
      cur_op <= mdf_pkg::MDF_OP_MULU;
      cur_size <= mdf_pkg::MDF_SZ_8;
      a_hold <= 24'h000000;
      b_hold <= 24'h000000;
    end else if (thread_end) begin
      state <= mdf_pkg::MDF_ST_IDLE;
      remain <= 4'h0;
    end else if (start) begin
      state <= mdf_pkg::MDF_ST_RUN;
      remain <= next_remain;
      cur_op <= op;
      cur_size <= size;
      a_hold <= first_operand;
      b_hold <= second_operand;
    end else begin
      case (state)
        mdf_pkg::MDF_ST_IDLE: begin
          remain <= 4'h0;
        end
        mdf_pkg::MDF_ST_RUN: begin
          if (remain == mdf_pkg::CNT_ONE) begin
            state <= mdf_pkg::MDF_ST_IDLE;
          end
          remain <= remain - mdf_pkg::CNT_ONE;
        end
        default: begin
          state <= mdf_pkg::MDF_ST_IDLE;
        end
      endcase
    end
  end

  // Busy while executing, false in the final microcycle
  assign muldiv_busy_flag = (state == mdf_pkg::MDF_ST_RUN) && (remain != mdf_pkg::CNT_ONE);

  // ==========================================================
  // Result words
  always_comb begin
    if (is_div) begin
      fin_result = {div_rem, (b_hold == mdf_pkg::WORD_ZERO) ? mdf_pkg::DIV_ZERO_QUOT : div_quot};
    end else begin
      fin_result = prod_result;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      result_high_word <= 24'h000000;
      result_low_word <= 24'h000000;
    end else if (finish) begin
      result_high_word <= fin_result[47:24];
      result_low_word <= fin_result[23:0];
    end
  end

  // ==========================================================
  // Flags: updated only at completion, untouched by thread start
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      muldiv_carry_flag <= 1'b0;
      muldiv_zero_flag <= 1'b0;
      muldiv_overflow_flag <= 1'b0;
      muldiv_negative_flag <= 1'b0;
    end else if (finish) begin
      muldiv_negative_flag <= fin_result[47];
      if (is_div) begin
        muldiv_carry_flag <= 1'b0;
        muldiv_zero_flag <= (fin_result[23:0] == mdf_pkg::WORD_ZERO);
        muldiv_overflow_flag <= (b_hold == mdf_pkg::WORD_ZERO);
      end else begin
        muldiv_zero_flag <= (fin_result == 48'h000000000000);
        if (cur_op == mdf_pkg::MDF_OP_MACS) begin
          muldiv_overflow_flag <= muldiv_overflow_flag | prod_ovf;
        end else if (cur_op == mdf_pkg::MDF_OP_MACU) begin
          muldiv_carry_flag <= muldiv_carry_flag | prod_ovf;
        end else begin
          muldiv_carry_flag <= 1'b0;
          muldiv_overflow_flag <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Semaphore lock condition, per thread
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      semaphore_locked_flag <= 1'b0;
    end else if (thread_start || thread_end || sem_free) begin
      semaphore_locked_flag <= 1'b0;
    end else if (sem_lock_try) begin
      semaphore_locked_flag <= sem_lock_won;
    end
  end

  // ==========================================================
  // Branch condition selection
  always_comb begin
    case (branch_group)
      mdf_pkg::MDF_GRP_ALU: branch_cond = alu_flags[branch_bit[1:0]];
      mdf_pkg::MDF_GRP_MDU: begin
        case (branch_bit)
          3'h0: branch_cond = muldiv_carry_flag;
          3'h1: branch_cond = muldiv_zero_flag;
          3'h2: branch_cond = muldiv_overflow_flag;
          3'h3: branch_cond = muldiv_negative_flag;
          default: branch_cond = muldiv_busy_flag;
        endcase
      end
      mdf_pkg::MDF_GRP_STAGE: branch_cond = staging_register[mdf_pkg::STAGE_FLAG_LSB + 32'(branch_bit)];
      mdf_pkg::MDF_GRP_CHAN: branch_cond = chan_flags[branch_bit];
      mdf_pkg::MDF_GRP_SEM: branch_cond = semaphore_locked_flag;
      default: branch_cond = 1'b0;
    endcase
  end

  // ==========================================================
  // Checks
  // Microcycles since a divide was taken, counted apart from the sequencer
  logic [3:0] div_age;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      div_age <= 4'h0;
    end else if (start && !thread_end && op == mdf_pkg::MDF_OP_DIVU) begin
      div_age <= mdf_pkg::CNT_ONE;
    end else if (start || thread_end) begin
      div_age <= 4'h0;
    end else if (div_age != 4'h0) begin
      div_age <= div_age + mdf_pkg::CNT_ONE;
    end
  end

  a_busy_after_start: assert property (@(posedge core_clk) disable iff (!rstn)
    start && !thread_end && op != mdf_pkg::MDF_OP_DIVU && size == mdf_pkg::MDF_SZ_16
      |=> muldiv_busy_flag ##1 !muldiv_busy_flag)
    else $error("busy flag timing wrong for 16-bit multiply");
  a_div_length: assert property (@(posedge core_clk) disable iff (!rstn)
    div_age != 4'h0 |-> finish == (div_age == mdf_pkg::DIV_CYCLES - mdf_pkg::CNT_ONE))
    else $error("divide did not take thirteen microcycles");
  a_mul8_length: assert property (@(posedge core_clk) disable iff (!rstn)
    start && !thread_end && op == mdf_pkg::MDF_OP_MULU && size == mdf_pkg::MDF_SZ_8
      |=> !muldiv_busy_flag && state == mdf_pkg::MDF_ST_RUN)
    else $error("8-bit multiply length wrong");
  a_end_aborts: assert property (@(posedge core_clk) disable iff (!rstn)
    thread_end |=> state == mdf_pkg::MDF_ST_IDLE && $stable(result_low_word))
    else $error("thread end did not abort operation");
  a_div_zero: assert property (@(posedge core_clk) disable iff (!rstn)
    finish && is_div && b_hold == mdf_pkg::WORD_ZERO
      |=> muldiv_overflow_flag && result_low_word == mdf_pkg::DIV_ZERO_QUOT)
    else $error("divide by zero result wrong");
  a_div_flags: assert property (@(posedge core_clk) disable iff (!rstn)
    finish && is_div |=> !muldiv_carry_flag
      && muldiv_negative_flag == result_high_word[23]
      && muldiv_zero_flag == (result_low_word == mdf_pkg::WORD_ZERO))
    else $error("divide flags wrong");
  a_mul_no_ovf: assert property (@(posedge core_clk) disable iff (!rstn)
    finish && !is_div && !is_mac |=> !muldiv_overflow_flag && !muldiv_carry_flag)
    else $error("multiply set carry or overflow");
  a_mul_zero: assert property (@(posedge core_clk) disable iff (!rstn)
    finish && !is_div |=> muldiv_zero_flag == ({result_high_word, result_low_word} == 48'h0)
      && muldiv_negative_flag == result_high_word[23])
    else $error("multiply zero or negative flag wrong");
  a_sem_clear: assert property (@(posedge core_clk) disable iff (!rstn)
    sem_free |=> !semaphore_locked_flag)
    else $error("semaphore flag not cleared by free");
  a_mac_sticky: assert property (@(posedge core_clk) disable iff (!rstn)
    finish && cur_op == mdf_pkg::MDF_OP_MACS && muldiv_overflow_flag |=> muldiv_overflow_flag)
    else $error("accumulate overflow flag was cleared");

  c_div_done: cover property (@(posedge core_clk) finish && is_div);
  c_mac_ovf: cover property (@(posedge core_clk) finish && is_mac && prod_ovf);
  c_abort: cover property (@(posedge core_clk) thread_end && state == mdf_pkg::MDF_ST_RUN);
  c_frac: cover property (@(posedge core_clk) finish && cur_op == mdf_pkg::MDF_OP_FMULU);

endmodule
`default_nettype wire

// File: verif/mdf_seq_model.sv
/*
  Sequencer and branch-side model that drives the multiply-divide unit.
  Assumes the bench calls one task at a time, just after a rising edge.
*/
`timescale 1ns/10ps
`default_nettype none

module mdf_seq_model #(
  parameter logic [3:0] ALU_PAT = 4'h6,
  parameter logic [7:0] CHAN_PAT = 8'h81,
  parameter logic [31:0] STG_PAT = 32'h5a000000
) (
  // Clock and unit status
  input wire logic core_clk,
  input wire logic muldiv_busy_flag,
  // Operation start
  output var logic start,
  output var mdf_pkg::mdf_op_e op,
  output var mdf_pkg::mdf_size_e size,
  output var logic [23:0] first_operand,
  output var logic [23:0] second_operand,
  // Thread and semaphore control
  output var logic thread_start,
  output var logic thread_end,
  output var logic sem_lock_try,
  output var logic sem_lock_won,
  output var logic sem_free,
  // Branch selection and flag sources
  output var mdf_pkg::mdf_grp_e branch_group,
  output var logic [2:0] branch_bit,
  output var logic [3:0] alu_flags,
  output var logic [7:0] chan_flags,
  output var logic [31:0] staging_register
);
  logic busy_mid;
  logic busy_last;

  // ==========================================================
  // Idle levels at time zero
  initial begin
    start = 1'b0;
    op = mdf_pkg::MDF_OP_MULU;
    size = mdf_pkg::MDF_SZ_8;
    first_operand = 24'h000000;
    second_operand = 24'h000000;
    {thread_start, thread_end, sem_lock_try, sem_lock_won, sem_free} = 5'h00;
    branch_group = mdf_pkg::MDF_GRP_ALU;
    branch_bit = 3'h0;
    alu_flags = ALU_PAT;
    chan_flags = CHAN_PAT;
    staging_register = STG_PAT;
  end

  // ==========================================================
  // One operation; c counts microcycles including the start cycle
  task automatic run(input mdf_pkg::mdf_op_e o, input mdf_pkg::mdf_size_e s,
                     input logic [23:0] a, input logic [23:0] b, input int c, input int cut);
    @(posedge core_clk);
    start <= 1'b1;
    op <= o;
    size <= s;
    first_operand <= a;
    second_operand <= b;
    @(posedge core_clk);
    start <= 1'b0;
    #1;
    busy_mid = muldiv_busy_flag;
    if (cut > 0) begin
      repeat (cut) @(posedge core_clk);
      thread_end <= 1'b1;
      @(posedge core_clk);
      thread_end <= 1'b0;
      repeat (c) @(posedge core_clk);
    end else begin
      repeat (c - 2) @(posedge core_clk);
    end
    #1;
    busy_last = muldiv_busy_flag;
    @(posedge core_clk);
    #1;
  endtask

  // One-cycle pulse of {thread_start, thread_end, try, won, free}
  task automatic ctl(input logic [4:0] v);
    @(posedge core_clk);
    {thread_start, thread_end, sem_lock_try, sem_lock_won, sem_free} <= v;
    @(posedge core_clk);
    {thread_start, thread_end, sem_lock_try, sem_lock_won, sem_free} <= 5'h00;
    #1;
  endtask

  task automatic br(input mdf_pkg::mdf_grp_e g, input logic [2:0] b);
    @(posedge core_clk);
    branch_group <= g;
    branch_bit <= b;
    #1;
  endtask
endmodule
`default_nettype wire

// File: verif/mdf_unit_test.sv
/*
  Self-checking bench for the multiply-divide unit and branch selector.
  Assumes the sequencer model drives every unit input except the clock and reset.
*/
`timescale 1ns/10ps
`default_nettype none

module mdf_unit_test;
  localparam logic [3:0] ALU_PAT = 4'h6;
  localparam logic [7:0] CHAN_PAT = 8'h81;
  localparam logic [31:0] STG_PAT = 32'h5a000000;
  localparam logic [7:0] MDU_PAT = 8'h08;
  logic core_clk;
  logic rstn;
  logic start, thread_start, thread_end, sem_lock_try, sem_lock_won, sem_free;
  mdf_pkg::mdf_op_e op;
  mdf_pkg::mdf_size_e size;
  mdf_pkg::mdf_grp_e branch_group;
  logic [2:0] branch_bit;
  logic [3:0] alu_flags;
  logic [7:0] chan_flags;
  logic [31:0] staging_register;
  logic [23:0] first_operand, second_operand, result_high_word, result_low_word;
  logic muldiv_carry_flag, muldiv_zero_flag, muldiv_overflow_flag, muldiv_negative_flag;
  logic muldiv_busy_flag, semaphore_locked_flag, branch_cond;
  logic [3:0] flg;
  logic [5:0] sem_tab [7];
  logic e;
  int n_fail = 0;
  int checks = 0;
  int cycles = 0;

  assign flg = {muldiv_negative_flag, muldiv_overflow_flag, muldiv_zero_flag, muldiv_carry_flag};

  mdf_unit u_mdf_unit (
    .core_clk(core_clk), .rstn(rstn), .start(start), .op(op), .size(size),
    .first_operand(first_operand), .second_operand(second_operand),
    .thread_start(thread_start), .thread_end(thread_end), .sem_lock_try(sem_lock_try),
    .sem_lock_won(sem_lock_won), .sem_free(sem_free), .branch_group(branch_group),
    .branch_bit(branch_bit), .alu_flags(alu_flags), .chan_flags(chan_flags),
    .staging_register(staging_register), .result_high_word(result_high_word),
    .result_low_word(result_low_word), .muldiv_carry_flag(muldiv_carry_flag),
    .muldiv_zero_flag(muldiv_zero_flag), .muldiv_overflow_flag(muldiv_overflow_flag),
    .muldiv_negative_flag(muldiv_negative_flag), .muldiv_busy_flag(muldiv_busy_flag),
    .semaphore_locked_flag(semaphore_locked_flag), .branch_cond(branch_cond)
  );

  mdf_seq_model #(.ALU_PAT(ALU_PAT), .CHAN_PAT(CHAN_PAT), .STG_PAT(STG_PAT)) u_mdf_seq_model (
    .core_clk(core_clk), .muldiv_busy_flag(muldiv_busy_flag), .start(start), .op(op),
    .size(size), .first_operand(first_operand), .second_operand(second_operand),
    .thread_start(thread_start), .thread_end(thread_end), .sem_lock_try(sem_lock_try),
    .sem_lock_won(sem_lock_won), .sem_free(sem_free), .branch_group(branch_group),
    .branch_bit(branch_bit), .alu_flags(alu_flags), .chan_flags(chan_flags),
    .staging_register(staging_register)
  );

  // ==========================================================
  // Clock, timeout and reporting
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic conclude();
    if (n_fail == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [47:0] got, input logic [47:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Runs one operation; z masks the undefined high word and the negative flag
  task automatic t(input logic [2:0] o, input logic [1:0] s, input int c, input logic [23:0] a,
                   input logic [23:0] b, input int cut, input logic z, input logic [47:0] r,
                   input logic [3:0] f);
    logic [47:0] m;
    logic [3:0] fm;
    m = z ? 48'h000000ffffff : 48'hffffffffffff;
    fm = z ? 4'h7 : 4'hf;
    u_mdf_seq_model.run(mdf_pkg::mdf_op_e'(o), mdf_pkg::mdf_size_e'(s), a, b, c, cut);
    check("result", {result_high_word, result_low_word} & m, r & m);
    check("flags", {44'h0, flg & fm}, {44'h0, f & fm});
    check("busy_mid", {47'h0, u_mdf_seq_model.busy_mid}, {47'h0, c > 2});
    check("busy_last", {47'h0, u_mdf_seq_model.busy_last}, 48'h0);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rstn = 1'b0;
    sem_tab = '{6'b100000, 6'b001101, 6'b000010, 6'b001000, 6'b001101, 6'b010000, 6'b001101};
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    t(3'h1, 2'h2, 4, 24'hffffff, 24'hffffff, 0, 0, 48'hfffffe000001, 4'h8);
    t(3'h3, 2'h2, 4, 24'hffffff, 24'hffffff, 0, 0, 48'hfffffc000002, 4'h9);
    t(3'h1, 2'h0, 2, 24'h000abc, 24'h000000, 0, 0, 48'h0, 4'h2);
    t(3'h1, 2'h1, 3, 24'h000002, 24'h008000, 0, 0, 48'h000000010000, 4'h0);
    t(3'h5, 2'h0, 2, 24'h000003, 24'h000080, 0, 0, 48'h000001800000, 4'h0);
    t(3'h5, 2'h1, 3, 24'h000005, 24'h008000, 0, 0, 48'h000002800000, 4'h0);
    t(3'h5, 2'h2, 4, 24'hffffff, 24'hffffff, 0, 0, 48'hfffffe000001, 4'h8);
    t(3'h4, 2'h0, 2, 24'hffffff, 24'h000080, 0, 0, 48'hffffff800000, 4'h8);
    t(3'h0, 2'h2, 4, 24'hffffff, 24'h000002, 0, 0, 48'hfffffffffffe, 4'h8);
    t(3'h1, 2'h2, 4, 24'h800000, 24'hffffff, 0, 0, 48'h7fffff800000, 4'h0);
    t(3'h2, 2'h2, 4, 24'h7fffff, 24'h7fffff, 0, 0, 48'hbffffe800001, 4'hc);
    t(3'h6, 2'h2, 13, 24'h000064, 24'h000007, 0, 0, 48'h00000200000e, 4'h0);
    t(3'h6, 2'h2, 13, 24'hfffffe, 24'hffffff, 0, 0, 48'hfffffe000000, 4'ha);
    t(3'h6, 2'h2, 13, 24'h123456, 24'h000000, 0, 1, 48'h000000ffffff, 4'h4);
    t(3'h6, 2'h2, 13, 24'h000064, 24'h000007, 3, 1, 48'h000000ffffff, 4'h4);
    for (int i = 0; i < 7; i++) begin
      u_mdf_seq_model.ctl(sem_tab[i][5:1]);
      check("semaphore", {47'h0, semaphore_locked_flag}, {47'h0, sem_tab[i][0]});
    end
    check("flags_kept", {44'h0, flg & 4'h7}, 48'h000000000004);
    t(3'h0, 2'h2, 4, 24'hffffff, 24'h000002, 0, 0, 48'hfffffffffffe, 4'h8);
    for (int g = 0; g < 5; g++) begin
      for (int b = 0; b < 8; b++) begin
        u_mdf_seq_model.br(mdf_pkg::mdf_grp_e'(g), 3'(b));
        case (g)
          0: e = ALU_PAT[b[1:0]];
          1: e = MDU_PAT[b];
          2: e = STG_PAT[24 + b];
          3: e = CHAN_PAT[b];
          default: e = 1'b1;
        endcase
        check("branch", {47'h0, branch_cond}, {47'h0, e});
      end
    end
    conclude();
  end
endmodule
`default_nettype wire
